// ---- rtl/spc_port.sv ----
// Serial port control: control register, buffer, shifter, pins.
// Assumes synchronous pins and a strobe register port.
`timescale 1ns/1ps
`include "spc_consts.svh"
`default_nettype none
module spc_port
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic sck_in,
    input wire logic sdi_in,
    input wire logic ss_n_in,
    output logic sck_out,
    output logic sck_oe_n_out,
    output logic sdo_out,
    output logic sdo_oe_n_out,
    output logic port_active_out,
    output logic ss_pin_free_out
);
    import spc_pkg::*;
    // ************************************************
    // Decode
    // ************************************************
    spc_ctrl_t ctrl_q;
    spc_state_t st_q;
    logic [7:0] buf_q, sr_q, rdata_q;
    logic full_q, busy_q, sck_q, sdo_q, sck_pin_q;
    logic [2:0] cnt_q;
    logic [5:0] div_q;
    wire wr_ctrl = wr_in && addr_in == `SPC_ADDR_CTRL;
    wire wr_buf = wr_in && addr_in == `SPC_ADDR_BUF;
    wire rd_buf = rd_in && addr_in == `SPC_ADDR_BUF;
    wire is_master = ctrl_q.mode == `SPC_MODE_DIV4
        || ctrl_q.mode == `SPC_MODE_DIV16
        || ctrl_q.mode == `SPC_MODE_DIV64;
    // RULE10 slave select gating
    wire slave_sel = (ctrl_q.mode == `SPC_MODE_SLV_SS && !ss_n_in)
        || ctrl_q.mode == `SPC_MODE_SLV_NOSS;
    wire [5:0] half = ctrl_q.mode == `SPC_MODE_DIV16 ? `SPC_HALF_DIV16
        : ctrl_q.mode == `SPC_MODE_DIV64 ? `SPC_HALF_DIV64
        : `SPC_HALF_DIV4;
    // RULE9 master rate enable pulse
    wire tick = div_q == half;
    // Slave edges seen relative to idle level
    wire s_lead = ctrl_q.en && slave_sel
        && (sck_in ^ ctrl_q.pol) && !(sck_pin_q ^ ctrl_q.pol);
    wire s_trail = ctrl_q.en && slave_sel
        && !(sck_in ^ ctrl_q.pol) && (sck_pin_q ^ ctrl_q.pol);
    wire m_lead = is_master && st_q == SPC_LEAD && tick;
    wire m_trail = is_master && st_q == SPC_TRAIL && tick;
    wire lead = m_lead || s_lead;
    wire trail = m_trail || s_trail;
    wire done = trail && cnt_q == 3'h7;
    // RULE1 write during shift collides
    wire coll = wr_buf && busy_q;
    // RULE2 RULE3 slave overflow only
    wire ovf = done && !is_master && full_q;
    // RULE4 master starts on buffer write
    wire start = wr_buf && !busy_q && ctrl_q.en;
    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= `SPC_CTRL_RESET;
            st_q <= SPC_IDLE;
            buf_q <= 8'h00;
            sr_q <= 8'h00;
            rdata_q <= 8'h00;
            full_q <= 1'b0;
            busy_q <= 1'b0;
            sck_q <= 1'b0;
            sdo_q <= 1'b0;
            sck_pin_q <= 1'b0;
            cnt_q <= 3'h0;
            div_q <= 6'h00;
        end
        else
        begin
            sck_pin_q <= sck_in;
            rdata_q <= addr_in == `SPC_ADDR_CTRL ? ctrl_q : buf_q;
            if (!rd_in)
                rdata_q <= 8'h00;
            // Set wins over a software clear
            if (wr_ctrl)
                ctrl_q <= wdata_in;
            if (coll)
                ctrl_q.coll <= 1'b1;
            if (ovf)
                ctrl_q.ovf <= 1'b1;
            div_q <= (st_q == SPC_IDLE || tick) ? 6'h00 : div_q + 6'h01;
            if (rd_buf)
                full_q <= 1'b0;
            // RULE12 shifter and buffer load
            if (start)
            begin
                sr_q <= wdata_in;
                sdo_q <= wdata_in[7];
                busy_q <= 1'b1;
                cnt_q <= 3'h0;
                if (is_master)
                    st_q <= SPC_LEAD;
            end
            else if (lead)
            begin
                sr_q <= {sr_q[6:0], sdi_in};
                if (is_master)
                    st_q <= SPC_TRAIL;
            end
            else if (trail)
            begin
                sdo_q <= sr_q[7];
                cnt_q <= cnt_q + 3'h1;
                st_q <= done || !is_master ? SPC_IDLE : SPC_LEAD;
                if (done)
                begin
                    busy_q <= 1'b0;
                    if (!ovf)
                    begin
                        buf_q <= sr_q;
                        full_q <= 1'b1;
                    end
                end
            end
            if (!ctrl_q.en)
            begin
                st_q <= SPC_IDLE;
                busy_q <= 1'b0;
            end
            // RULE8 clock idle level
            sck_q <= ctrl_q.pol ^ (st_q == SPC_TRAIL);
        end
    end
    // ************************************************
    // Pins
    // ************************************************
    // RULE6 pin takeover by enable
    logic sck_oe_q, sdo_oe_q, act_q, ssf_q;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sck_oe_q <= 1'b1;
            sdo_oe_q <= 1'b1;
            act_q <= 1'b0;
            ssf_q <= 1'b1;
        end
        else
        begin
            sck_oe_q <= !(ctrl_q.en && is_master);
            sdo_oe_q <= !ctrl_q.en;
            act_q <= ctrl_q.en;
            ssf_q <= !ctrl_q.en || ctrl_q.mode != `SPC_MODE_SLV_SS;
        end
    end
    assign rdata_out = rdata_q;
    assign sck_out = sck_q;
    assign sdo_out = sdo_q;
    assign sck_oe_n_out = sck_oe_q;
    assign sdo_oe_n_out = sdo_oe_q;
    assign port_active_out = act_q;
    assign ss_pin_free_out = ssf_q;
    // ************************************************
    // Checks
    // ************************************************
    a_coll_set: assert property ( // RULE1
        @(posedge clk_in) disable iff (sys_rst_in)
        coll |=> ctrl_q.coll)
        else $error("collision flag not set");
    a_ovf_slave: assert property ( // RULE3
        @(posedge clk_in) disable iff (sys_rst_in)
        is_master && !wr_ctrl |=> !$rose(ctrl_q.ovf))
        else $error("overflow raised in master");
    a_ovf_set: assert property ( // RULE2
        @(posedge clk_in) disable iff (sys_rst_in)
        ovf |=> ctrl_q.ovf && $stable(buf_q))
        else $error("overflow handling wrong");
    a_master_start: assert property ( // RULE4
        @(posedge clk_in) disable iff (sys_rst_in)
        $rose(busy_q) |-> $past(wr_buf))
        else $error("transfer without buffer write");
    a_idle_level: assert property ( // RULE8
        @(posedge clk_in) disable iff (sys_rst_in)
        st_q == SPC_IDLE ##1 st_q == SPC_IDLE
        |-> sck_q == $past(ctrl_q.pol))
        else $error("clock idle level wrong");
    a_pin_enable: assert property ( // RULE6
        @(posedge clk_in) disable iff (sys_rst_in)
        !ctrl_q.en |=> sdo_oe_q && sck_oe_q)
        else $error("pins driven while disabled");
    a_div_rate: assert property ( // RULE9
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_q.mode == `SPC_MODE_DIV4 && m_lead && !wr_ctrl
        |-> ##2 m_trail)
        else $error("divide by four rate wrong");
    a_div16_rate: assert property ( // RULE9
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_q.mode == `SPC_MODE_DIV16 && m_lead && !wr_ctrl
        |-> ##8 m_trail)
        else $error("divide by sixteen rate wrong");
    a_div64_rate: assert property ( // RULE9
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_q.mode == `SPC_MODE_DIV64 && m_lead && !wr_ctrl
        |-> ##32 m_trail)
        else $error("divide by sixty-four rate wrong");
    a_pin_take: assert property ( // RULE6
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_q.en |=> !sdo_oe_q && act_q)
        else $error("pins not taken when enabled");
    a_slave_clk: assert property ( // RULE10
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_q.en && !is_master |=> sck_oe_q)
        else $error("slave drives serial clock");
    a_buf_load: assert property ( // RULE12
        @(posedge clk_in) disable iff (sys_rst_in)
        done && !ovf |=> full_q && buf_q == $past(sr_q))
        else $error("buffer not loaded");
endmodule : spc_port
`default_nettype wire

// ---- rtl/spc_consts.svh ----
// Constants of the serial port control block.
// Assumes a single 125 MHz clock domain.
//
// Contract
// RULE1 - Buffer write while shifting sets collision flag
// RULE2 - Slave byte into full buffer sets overflow
// RULE3 - Overflow never set in master operation
// RULE4 - Master transfer starts only on buffer write
// RULE5 - Software reads buffer after every transfer
// RULE6 - Enable bit hands pins to the port
// RULE7 - Software sets serial pin directions itself; the port drives the pin output enables from the enable bit and mode
// RULE8 - Polarity bit picks idle clock level
// RULE9 - Codes 0000/0001/0010 give master divide 4/16/64
// RULE10 - Codes 0100/0101 slave with or without select
// RULE11 - Software avoids reserved mode codes
// RULE12 - Eight-bit shift register loads receive buffer
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_ADDR_CTRL 2'h0
`define SPC_ADDR_BUF 2'h1
`define SPC_CTRL_RESET 8'h00
`define SPC_BIT_COLL 7
`define SPC_BIT_OVF 6
`define SPC_BIT_EN 5
`define SPC_BIT_POL 4
`define SPC_MODE_DIV4 4'h0
`define SPC_MODE_DIV16 4'h1
`define SPC_MODE_DIV64 4'h2
`define SPC_MODE_SLV_SS 4'h4
`define SPC_MODE_SLV_NOSS 4'h5
`define SPC_HALF_DIV4 6'h01
`define SPC_HALF_DIV16 6'h07
`define SPC_HALF_DIV64 6'h1F
`endif

// ---- rtl/spc_pkg.sv ----
// Types of the serial port control block.
// Assumes the constants header is included by users.
package spc_pkg;
    typedef struct packed {
        logic coll;
        logic ovf;
        logic en;
        logic pol;
        logic [3:0] mode;
    } spc_ctrl_t;
    typedef enum logic [1:0] {
        SPC_IDLE = 2'h0,
        SPC_LEAD = 2'h1,
        SPC_TRAIL = 2'h3
    } spc_state_t;
endpackage : spc_pkg

// ---- test/spc_far_end.sv ----
// Far-end serial device: shifts one byte out and captures one in.
// Assumes an idle-low clock; the bench calls send to act as master.
`timescale 1ns/1ps
`default_nettype none
module spc_far_end
(
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic rst_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic drv_sck_out,
    output logic ss_n_out,
    output logic [7:0] rx_out
);
    logic [2:0] cnt_q;
    // Sample on leading edge, shift on trailing
    always @(posedge sck_in)
        rx_out <= {rx_out[6:0], mosi_in};
    always @(negedge sck_in or posedge rst_in)
        cnt_q <= rst_in ? 3'h0 : cnt_q + 3'h1;
    assign miso_out = tx_in[3'h7 - cnt_q];
    initial
    begin
        drv_sck_out = 1'b0;
        ss_n_out = 1'b1;
    end
    // Clock stands still outside frames; gap lets select be seen
    task send();
        // Start off the clock edge so pins never race the sampler
        #2 ss_n_out = 1'b0;
        repeat (16) #40 drv_sck_out = ~drv_sck_out;
        #40 ss_n_out = 1'b1;
        #80;
    endtask : send
endmodule : spc_far_end
`default_nettype wire

// ---- test/spc_port_tb_top.sv ----
// Bench for the serial port control block.
// Assumes the far-end model and a one-cycle read port.
`timescale 1ns/1ps
`include "spc_consts.svh"
`default_nettype none
module spc_port_tb_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [1:0] addr_in = 2'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic cnt_en = 1'b0;
    logic [7:0] rdata_out, rd_v, pm_rx, pm_tx = 8'h00;
    logic sck_in, sdi_in, ss_n_in, pm_sck, sck_out, sck_oe_n_out;
    logic sdo_out, sdo_oe_n_out, port_active_out, ss_pin_free_out;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int hi = 0;
    int dv;
    // listed modes only
    // Control byte, then clock drive, select free, data drive
    logic [10:0] rows [6] = '{{8'h20, 3'h2}, {8'h31, 3'h2},
        {8'h22, 3'h2}, {8'h24, 3'h4}, {8'h25, 3'h6}, {8'h14, 3'h7}};
    assign sck_in = sck_oe_n_out ? pm_sck : sck_out;
    spc_port DUT (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .sck_in(sck_in),
        .sdi_in(sdi_in),
        .ss_n_in(ss_n_in),
        .sck_out(sck_out),
        .sck_oe_n_out(sck_oe_n_out),
        .sdo_out(sdo_out),
        .sdo_oe_n_out(sdo_oe_n_out),
        .port_active_out(port_active_out),
        .ss_pin_free_out(ss_pin_free_out)
    );
    spc_far_end pm (.sck_in(sck_in), .mosi_in(sdo_out), .rst_in(sys_rst_in),
        .tx_in(pm_tx), .miso_out(sdi_in), .drv_sck_out(pm_sck),
        .ss_n_out(ss_n_in), .rx_out(pm_rx));
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        hi <= cnt_en ? hi + int'(sck_out) : 0;
        if (cyc == 20000)
            summarize();
    end
    task summarize();
        if (cyc >= 20000)
            err_total++;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rd_v = rdata_out;
    endtask : rd
    task rst();
        sys_rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
    endtask : rst
    initial
    begin
        rst();
        foreach (rows[i])
        begin
            wr(`SPC_ADDR_CTRL, rows[i][10:3]);
            rd(`SPC_ADDR_CTRL);
            chk(rd_v, rows[i][10:3]);
            chk({4'h0, port_active_out, sck_oe_n_out, ss_pin_free_out,
                sdo_oe_n_out}, {4'h0, rows[i][8], rows[i][2:0]});
            if (!rows[i][2])
                chk({7'h0, sck_out}, {7'h0, rows[i][7]});
        end
        wr(`SPC_ADDR_CTRL, 8'h31);
        rst();
        chk({3'h0, sck_out, port_active_out, sck_oe_n_out, ss_pin_free_out,
            sdo_oe_n_out}, 8'h07);
        rd(`SPC_ADDR_CTRL);
        chk(rd_v, `SPC_CTRL_RESET);
        $display("test rows and reset done");
        for (int m = 0; m < 3; m++)
        begin
            dv = 4 << (2 * m);
            pm_tx = 8'h5A ^ 8'(m);
            wr(`SPC_ADDR_CTRL, 8'h20 | 8'(m));
            cnt_en <= 1'b1;
            wr(`SPC_ADDR_BUF, 8'h81 + 8'(m));
            wr(`SPC_ADDR_BUF, 8'hFF);
            repeat (10 * dv) @(posedge clk_in);
            chk(8'(hi), 8'(4 * dv));
            chk(hi[9:2], 8'(dv));
            cnt_en <= 1'b0;
            rd(`SPC_ADDR_CTRL);
            chk(rd_v, 8'hA0 | 8'(m));
            rd(`SPC_ADDR_BUF);
            chk(rd_v, pm_tx);
            chk(pm_rx, 8'h81 + 8'(m));
        end
        wr(`SPC_ADDR_BUF, 8'h11);
        repeat (700) @(posedge clk_in);
        wr(`SPC_ADDR_BUF, 8'h22);
        repeat (700) @(posedge clk_in);
        rd(`SPC_ADDR_CTRL);
        chk(rd_v, 8'hA2);
        rd(`SPC_ADDR_BUF);
        chk(rd_v, pm_tx);
        $display("test master done");
        wr(`SPC_ADDR_CTRL, 8'h24);
        wr(`SPC_ADDR_BUF, 8'h96);
        pm_tx = 8'h3C;
        pm.send();
        rd(`SPC_ADDR_BUF);
        chk(rd_v, 8'h3C);
        chk(pm_rx, 8'h96);
        pm_tx = 8'h71;
        pm.send();
        pm_tx = 8'hE8;
        pm.send();
        rd(`SPC_ADDR_CTRL);
        chk(rd_v, 8'h64);
        rd(`SPC_ADDR_BUF);
        chk(rd_v, 8'h71);
        wr(`SPC_ADDR_CTRL, 8'h25);
        pm_tx = 8'hC3;
        pm.send();
        rd(`SPC_ADDR_BUF);
        chk(rd_v, 8'hC3);
        $display("test slave done");
        summarize();
    end
endmodule : spc_port_tb_top
`default_nettype wire
